// ### verilog/fpa_pkg.sv
// Purpose: shared constants of the flash protection and abort controller
// Assumes: 50 MHz pclk, 32-bit register words, two 128 kB flash blocks
// Notes:   offsets are byte addresses inside the controller window
package fpa_pkg;
  localparam logic [31:0] USER_KEY        = 32'hf123f456;
  localparam logic [31:0] RP_VALUE        = 32'h0000003a;
  localparam logic [31:0] PRO_RST         = 32'hffffffff;
  localparam logic [31:0] CSETUP_RST      = 32'h00000002;
  localparam logic [31:0] CON1_RST        = 32'h00000001;

  localparam logic [7:0]  OFF_STA    = 8'h00;
  localparam logic [7:0]  OFF_CON0   = 8'h04;
  localparam logic [7:0]  OFF_CMD    = 8'h08;
  localparam logic [7:0]  OFF_FLADR  = 8'h0c;
  localparam logic [7:0]  OFF_DATA0  = 8'h10;
  localparam logic [7:0]  OFF_DATA1  = 8'h14;
  localparam logic [7:0]  OFF_ADR0   = 8'h18;
  localparam logic [7:0]  OFF_ADR1   = 8'h1c;
  localparam logic [7:0]  OFF_KEY    = 8'h20;
  localparam logic [7:0]  OFF_PRO0   = 8'h28;
  localparam logic [7:0]  OFF_PRO1   = 8'h2c;
  localparam logic [7:0]  OFF_SIG    = 8'h34;
  localparam logic [7:0]  OFF_CON1   = 8'h38;
  localparam logic [7:0]  OFF_AEN0   = 8'h48;
  localparam logic [7:0]  OFF_AEN1   = 8'h4c;
  localparam logic [7:0]  OFF_CSTAT  = 8'hc0;
  localparam logic [7:0]  OFF_CSETUP = 8'hc4;
  localparam logic [7:0]  OFF_CKEY   = 8'hc8;

  localparam int STA_BUSY   = 0;
  localparam int STA_DONE   = 2;
  localparam int STA_RES_LO = 4;
  localparam int STA_FAIL   = 6;
  localparam int STA_ECC_LO = 7;
  localparam int CON0_IE    = 0;
  localparam int CON1_SWD   = 0;
  localparam int CON1_KHDMA = 2;
  localparam int CACHE_I    = 0;
  localparam int CACHE_D    = 16;
  localparam int BLK_BIT    = 17;
  localparam int PAGE_LO    = 12;
  localparam int NUM_IRQ    = 55;

  localparam logic [1:0] RES_OK     = 2'h0;
  localparam logic [1:0] RES_DENIED = 2'h1;
  localparam logic [1:0] RES_PROT   = 2'h2;
  localparam logic [1:0] RES_ABORT  = 2'h3;

  localparam logic [3:0] CMD_IDLE   = 4'h0;
  localparam logic [3:0] CMD_SIGN   = 4'h2;
  localparam logic [3:0] CMD_PERASE = 4'h4;
  localparam logic [3:0] CMD_MERASE0 = 4'h5;
  localparam logic [3:0] CMD_MERASE1 = 4'h6;
  localparam logic [3:0] CMD_MVERIFY = 4'h7;
  localparam logic [3:0] CMD_ABORT  = 4'h8;
  localparam logic [3:0] CMD_WRITE  = 4'hf;

  localparam int CNT_W         = 20;
  localparam int CLK_NS        = 20;
  localparam int WRITE_NS      = 75000;
  localparam int ERASE_MS      = 18;
  localparam int SIGN_INFO_CYC = 512;
  localparam int SIGN_USER_CYC = 32768;
  localparam int WRITE_CYC     = WRITE_NS / CLK_NS;
  localparam int ERASE_CYC     = ERASE_MS * 1000000 / CLK_NS;
  localparam int CACHE_INIT_CYC = 16;

  localparam logic [7:0] HOFF_ADDR  = 8'h00;
  localparam logic [7:0] HOFF_WDATA = 8'h04;
  localparam logic [7:0] HOFF_GO    = 8'h08;
  localparam logic [7:0] HOFF_RDATA = 8'h0c;
  localparam logic [7:0] HOFF_STAT  = 8'h10;
  localparam int HADDR_WE = 8;

  function automatic logic fpa_page_prot(input logic [31:0] pro, input logic [31:0] addr);
    return pro[addr[PAGE_LO+4:PAGE_LO]];
  endfunction : fpa_page_prot
endpackage : fpa_pkg

// ### verilog/fpa_link_if.sv
// Purpose: register link between the controller end and the flash device end
// Assumes: one request at a time, request held until ack
// Notes:   ack is a one-cycle pulse with rdata valid in the same cycle
`timescale 1ns/1ps
interface fpa_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;

  modport dev  (input req, we, addr, wdata, output ack, rdata);
  modport host (output req, we, addr, wdata, input ack, rdata);
endinterface : fpa_link_if

// ### verilog/fpa_op_timer.sv
// Purpose: duration counter of one flash block operation
// Assumes: start and kill are single-cycle pulses
// Notes:   kill stops the count without a done pulse
`timescale 1ns/1ps
module fpa_op_timer
  import fpa_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] cycles,
  input  wire logic             kill,
  output logic                  busy,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (kill) begin
        busy <= 1'b0;
      end else if (start) begin
        cnt_q <= cycles;
        busy  <= 1'b1;
      end else if (busy) begin
        if (cnt_q <= 1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : fpa_op_timer

// ### verilog/fpa_flash_dev.sv
// Purpose: key, read and write protection, abort and cache control of a two-block flash
// Assumes: link requests held until ack; irq and array inputs are on pclk
// Notes:   array work is modelled by per-block duration timers
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module fpa_flash_dev
  import fpa_pkg::*;
#(
  parameter int ERASE_CYCLES     = ERASE_CYC,
  parameter int SIGN_USER_CYCLES = SIGN_USER_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  fpa_link_if.dev                 lnk,
  input  wire logic [NUM_IRQ-1:0] irq_lines,
  input  wire logic               kernel_run,
  input  wire logic [31:0]        prot_word0,
  input  wire logic [31:0]        prot_word1,
  input  wire logic [31:0]        rp_key0,
  input  wire logic [31:0]        rp_key1,
  input  wire logic               ecc_fix,
  input  wire logic               ecc_fail,
  input  wire logic [23:0]        sign_crc,
  input  wire logic               dl_mass_req,
  input  wire logic               dl_page_req,
  input  wire logic [31:0]        dl_addr,
  input  wire logic               fetch_req,
  input  wire logic               fetch_blk,
  output logic                    swd_enable,
  output logic                    fetch_stall,
  output logic                    cmd_irq,
  output logic                    dl_reject,
  output logic [1:0]              cache_inval
);
  typedef enum logic [1:0] {FPA_IDLE, FPA_RUN, FPA_DL2} fpa_state_t;

  fpa_state_t  st_q;
  logic        ack_q, key_q, ckey_q, rp_lock_q, loaded_q, kern_q;
  logic [31:0] rdata_q, con0_q, con1_q, fladr_q, data0_q, adr0_q, adr1_q;
  logic [31:0] pro0_q, pro1_q, aen0_q, csetup_q;
  logic [22:0] aen1_q;
  logic [23:0] sig_q;
  logic        busy_q, done_q, fail_q, op_blk_q, ecc1_q, ecc2_q, dl_first_q;
  logic [1:0]  res_q, ecc_flags_q;
  logic [3:0]  kind_q;
  logic [1:0]  cstat_q;
  logic [4:0]  ccnt_q;
  logic        acc, wr, abort_hit, khdma_go;
  logic        go, go_blk;
  logic [3:0]  go_kind;
  logic [31:0] go_addr;
  logic [CNT_W-1:0] go_cyc;
  logic [1:0]  t_start, t_kill, t_busy, t_done;

  assign acc = lnk.req & ~ack_q;
  assign wr  = acc & lnk.we;
  assign lnk.ack   = ack_q;
  assign lnk.rdata = rdata_q;
  assign abort_hit = |({aen1_q, aen0_q} & irq_lines);
  assign fetch_stall = fetch_req & t_busy[fetch_blk];

  function automatic logic [CNT_W-1:0] op_cycles(input logic [3:0] k, input logic info);
    case (k)
      CMD_WRITE:  op_cycles = CNT_W'(WRITE_CYC);
      CMD_SIGN:   op_cycles = info ? CNT_W'(SIGN_INFO_CYC) : CNT_W'(SIGN_USER_CYCLES);
      CMD_MVERIFY: op_cycles = CNT_W'(SIGN_USER_CYCLES);
      default:    op_cycles = CNT_W'(ERASE_CYCLES);
    endcase
  endfunction : op_cycles

  // the keyhole upper word launches a 64-bit write
  assign khdma_go = wr && lnk.addr == OFF_DATA1 && (key_q || con1_q[CON1_KHDMA]);

  always_comb begin
    go      = 1'b0;
    go_kind = CMD_IDLE;
    go_addr = adr0_q;
    go_blk  = 1'b0;
    if (st_q == FPA_IDLE) begin
      if (wr && lnk.addr == OFF_CMD && lnk.wdata[3:0] != CMD_ABORT && lnk.wdata[3:0] != CMD_IDLE) begin
        go      = 1'b1;
        go_kind = lnk.wdata[3:0];
      end else if (khdma_go) begin
        go      = 1'b1;
        go_kind = CMD_WRITE;
        go_addr = fladr_q;
      end else if (dl_page_req) begin
        go      = ~rp_lock_q;
        go_kind = CMD_PERASE;
        go_addr = dl_addr;
      end else if (dl_mass_req) begin
        go      = 1'b1;
        go_kind = rp_key0 == RP_VALUE ? CMD_MERASE1 : CMD_MERASE0;
      end
    end
    case (go_kind)
      CMD_MERASE0: go_blk = 1'b0;
      CMD_MERASE1: go_blk = 1'b1;
      default:     go_blk = go_addr[BLK_BIT];
    endcase
    go_cyc = op_cycles(go_kind, adr0_q[16:11] == adr1_q[16:11]);
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_blk
      fpa_op_timer u_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (t_start[gi]),
        .cycles  (go_cyc),
        .kill    (t_kill[gi]),
        .busy    (t_busy[gi]),
        .done    (t_done[gi])
      );
    end
  endgenerate

  logic denied, prot_hit, start_ok, cmd_abort, run_abort;
  // keyhole path already demanded the key or the dma enable
  assign denied    = go && wr && !key_q && !khdma_go;
  assign prot_hit  = go && (go_kind == CMD_WRITE || go_kind == CMD_PERASE) &&
                     fpa_page_prot(go_blk ? pro1_q : pro0_q, go_addr);
  assign start_ok  = go && !denied && !prot_hit && !abort_hit;
  assign cmd_abort = wr && lnk.addr == OFF_CMD && lnk.wdata[3:0] == CMD_ABORT;
  assign run_abort = st_q != FPA_IDLE && (abort_hit || cmd_abort);

  always_comb begin
    t_start = 2'b00;
    t_kill  = 2'b00;
    if (start_ok) t_start[go_blk] = 1'b1;
    if (st_q == FPA_DL2 && t_done[op_blk_q]) t_start[~op_blk_q] = 1'b1;
    if (run_abort) t_kill[op_blk_q] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= FPA_IDLE; busy_q <= 1'b0; done_q <= 1'b0; fail_q <= 1'b0;
      res_q <= RES_OK; kind_q <= CMD_IDLE; op_blk_q <= 1'b0; dl_first_q <= 1'b0;
      ecc1_q <= 1'b0; ecc2_q <= 1'b0; ecc_flags_q <= 2'b00; sig_q <= '0;
      cmd_irq <= 1'b0; dl_reject <= 1'b0;
    end else begin
      cmd_irq   <= 1'b0;
      dl_reject <= st_q == FPA_IDLE && dl_page_req && rp_lock_q;
      if (st_q != FPA_IDLE && kind_q == CMD_SIGN) begin
        ecc1_q <= ecc1_q | ecc_fix;
        ecc2_q <= ecc2_q | ecc_fail;
      end
      case (st_q)
        FPA_IDLE: begin
          if (go) begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            kind_q <= go_kind;
            op_blk_q <= go_blk;
            ecc1_q <= 1'b0;
            ecc2_q <= 1'b0;
            if (denied) begin
              res_q <= RES_DENIED;
              done_q <= 1'b1;
            end else if (prot_hit) begin
              res_q <= RES_PROT;
              done_q <= 1'b1;
              cmd_irq <= con0_q[CON0_IE];
            end else if (abort_hit) begin
              res_q <= RES_ABORT;
              fail_q <= 1'b1;
              done_q <= 1'b1;
            end else begin
              busy_q <= 1'b1;
              st_q <= go_kind == CMD_PERASE || !dl_mass_req || wr ? FPA_RUN : FPA_DL2;
              dl_first_q <= dl_mass_req && !wr && !khdma_go && !dl_page_req;
            end
          end
        end
        FPA_RUN, FPA_DL2: begin
          if (run_abort) begin
            res_q  <= RES_ABORT;
            fail_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q   <= FPA_IDLE;
            cmd_irq <= con0_q[CON0_IE];
          end else if (t_done[op_blk_q]) begin
            if (st_q == FPA_DL2) begin
              op_blk_q <= ~op_blk_q;
              st_q <= FPA_RUN;
            end else begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              res_q  <= RES_OK;
              st_q   <= FPA_IDLE;
              cmd_irq <= con0_q[CON0_IE];
              if (kind_q == CMD_SIGN) begin
                ecc_flags_q <= {ecc2_q | ecc_fail, ecc1_q | ecc_fix};
                if (!(ecc1_q | ecc2_q | ecc_fix | ecc_fail)) sig_q <= sign_crc;
              end
            end
          end
        end
        default: st_q <= FPA_IDLE;
      endcase
    end
  end

  // protection loaded on the first cycle out of reset, straps not sampled under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0; pro0_q <= PRO_RST; pro1_q <= PRO_RST;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      pro0_q <= prot_word0;
      pro1_q <= prot_word1;
    end else if (wr && key_q && lnk.addr == OFF_PRO0) begin
      pro0_q <= lnk.wdata;
    end else if (wr && key_q && lnk.addr == OFF_PRO1) begin
      pro1_q <= lnk.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= 1'b0;
    end else if (wr && lnk.addr == OFF_KEY) begin
      key_q <= lnk.wdata == USER_KEY;
    end else if (wr && lnk.addr == OFF_CMD) begin
      key_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kern_q <= 1'b1; rp_lock_q <= 1'b0; swd_enable <= 1'b0; con1_q <= CON1_RST;
    end else begin
      kern_q <= kernel_run;
      if (wr && key_q && lnk.addr == OFF_CON1) con1_q <= lnk.wdata;
      if (kernel_run) begin
        swd_enable <= 1'b0;
      end else if (kern_q) begin
        rp_lock_q  <= rp_key0 == RP_VALUE || rp_key1 == RP_VALUE;
        swd_enable <= !(rp_key0 == RP_VALUE || rp_key1 == RP_VALUE) && con1_q[CON1_SWD];
      end else begin
        swd_enable <= !rp_lock_q && con1_q[CON1_SWD];
      end
      // lock lifts only once both blocks are gone
      if (st_q == FPA_RUN && dl_first_q && t_done[op_blk_q]) rp_lock_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ckey_q <= 1'b0; csetup_q <= CSETUP_RST; cstat_q <= 2'b00; ccnt_q <= '0; cache_inval <= 2'b00;
    end else begin
      cache_inval <= 2'b00;
      if (wr && lnk.addr == OFF_CKEY) ckey_q <= lnk.wdata == USER_KEY;
      if (wr && lnk.addr == OFF_CSETUP && ckey_q) begin
        csetup_q <= lnk.wdata;
        ckey_q   <= 1'b0;
        if (lnk.wdata[CACHE_I] || lnk.wdata[CACHE_D]) begin
          cstat_q <= {lnk.wdata[CACHE_D], lnk.wdata[CACHE_I]};
          cache_inval <= {lnk.wdata[CACHE_D], lnk.wdata[CACHE_I]};
          ccnt_q  <= 5'(CACHE_INIT_CYC);
        end
      end else if (ccnt_q != 0) begin
        ccnt_q <= ccnt_q - 1'b1;
        if (ccnt_q == 5'd1) cstat_q <= 2'b00;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con0_q <= '0; fladr_q <= '0; data0_q <= '0; adr0_q <= '0; adr1_q <= '0;
      aen0_q <= '0; aen1_q <= '0;
    end else if (wr) begin
      case (lnk.addr)
        OFF_CON0:  con0_q  <= lnk.wdata;
        OFF_FLADR: fladr_q <= lnk.wdata;
        OFF_DATA0: data0_q <= lnk.wdata;
        OFF_ADR0:  adr0_q  <= lnk.wdata;
        OFF_ADR1:  adr1_q  <= lnk.wdata;
        OFF_AEN0:  aen0_q  <= lnk.wdata;
        OFF_AEN1:  aen1_q  <= lnk.wdata[22:0];
        default:   ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0; rdata_q <= '0;
    end else begin
      ack_q <= acc;
      if (acc && !lnk.we) begin
        case (lnk.addr)
          OFF_STA:    rdata_q <= {23'h0, ecc_flags_q, fail_q, res_q, 1'b0, done_q, 1'b0, busy_q};
          OFF_CON0:   rdata_q <= con0_q;
          OFF_FLADR:  rdata_q <= fladr_q;
          OFF_DATA0:  rdata_q <= data0_q;
          OFF_ADR0:   rdata_q <= adr0_q;
          OFF_ADR1:   rdata_q <= adr1_q;
          OFF_PRO0:   rdata_q <= pro0_q;
          OFF_PRO1:   rdata_q <= pro1_q;
          OFF_SIG:    rdata_q <= {8'h0, sig_q};
          OFF_CON1:   rdata_q <= con1_q;
          OFF_AEN0:   rdata_q <= aen0_q;
          OFF_AEN1:   rdata_q <= {9'h0, aen1_q};
          OFF_CSTAT:  rdata_q <= {15'h0, cstat_q[1], 15'h0, cstat_q[0]};
          OFF_CSETUP: rdata_q <= csetup_q;
          default:    rdata_q <= '0;
        endcase
      end
    end
  end
endmodule : fpa_flash_dev

// ### verilog/fpa_link_ctrl.sv
// Purpose: APB-controlled master of the flash register link
// Assumes: software writes address, data, then go, and polls status
// Notes:   one link access in flight; go while busy is ignored
`timescale 1ns/1ps
module fpa_link_ctrl
  import fpa_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  fpa_link_if.host         lnk
);
  logic [8:0]  addr_q;
  logic [31:0] wdata_q, rdata_q;
  logic        busy_q, done_q, req_q;
  logic        apb_acc, mapped;

  assign apb_acc = psel & penable;
  assign pready  = 1'b1;
  assign mapped  = paddr == HOFF_ADDR || paddr == HOFF_WDATA || paddr == HOFF_GO ||
                   paddr == HOFF_RDATA || paddr == HOFF_STAT;
  assign pslverr = apb_acc & ~mapped;
  assign lnk.req   = req_q;
  assign lnk.we    = addr_q[HADDR_WE];
  assign lnk.addr  = addr_q[7:0];
  assign lnk.wdata = wdata_q;

  always_comb begin
    case (paddr)
      HOFF_ADDR:  prdata = {23'h0, addr_q};
      HOFF_WDATA: prdata = wdata_q;
      HOFF_RDATA: prdata = rdata_q;
      HOFF_STAT:  prdata = {30'h0, done_q, busy_q};
      default:    prdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0; wdata_q <= '0;
    end else if (apb_acc && pwrite && !busy_q) begin
      if (paddr == HOFF_ADDR)  addr_q  <= pwdata[8:0];
      if (paddr == HOFF_WDATA) wdata_q <= pwdata;
    end
  end

  // request held until the device acks, as the link requires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0; done_q <= 1'b0; req_q <= 1'b0; rdata_q <= '0;
    end else if (busy_q) begin
      if (lnk.ack) begin
        req_q  <= 1'b0;
        busy_q <= 1'b0;
        done_q <= 1'b1;
        if (!addr_q[HADDR_WE]) rdata_q <= lnk.rdata;
      end
    end else if (apb_acc && pwrite && paddr == HOFF_GO && pwdata[0]) begin
      req_q  <= 1'b1;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end
  end
endmodule : fpa_link_ctrl

// ### verif/fpa_assertions.sv
// Purpose: link handshake checks between the two flash ends
// Assumes: plain copies of the link interface signals
// Notes:   ack is fixed at one cycle after a take
`timescale 1ns/1ps
module fpa_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        req,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_close;
    ack ##1 !req;
  endsequence
  AST_TAKE_ACK: assert property (s_take |=> s_close) else $error("no ack after take");
  AST_ACK_PULSE: assert property (ack |=> !ack) else $error("ack too long");
  AST_ACK_CAUSE: assert property (ack |-> req) else $error("ack without request");
  AST_IDLE_QUIET: assert property (!req |=> !ack) else $error("ack while idle");
  AST_REQ_HOLD: assert property (s_take |=> $stable({we, addr, wdata})) else $error("request moved");
  AST_REQ_HELD: assert property (s_take |-> req [*2]) else $error("request dropped early");
  AST_RDATA_KEEP: assert property (!(req && !we && !ack) |=> $stable(rdata)) else $error("rdata moved");
  AST_ALIGNED: assert property (req |-> addr[1:0] == 2'h0) else $error("unaligned offset");
endmodule : fpa_assertions

// ### verif/flash_protect_abort_ctrl_bench.sv
// Purpose: self-checking bench of controller and flash ends joined by the link
// Assumes: flash and link status are polled, never timed; cache status is read after a fixed wait
// Notes:   erase and user sign shortened to keep the run short
`timescale 1ns/1ps
module flash_protect_abort_ctrl_bench
  import fpa_pkg::*;
;
  localparam logic [31:0] PW0 = 32'h00000010;
  localparam logic [39:0] ROWS [6] = '{{OFF_PRO0, PW0}, {OFF_PRO1, ~PW0}, {OFF_CON1, CON1_RST},
                                      {OFF_CSETUP, CSETUP_RST}, {OFF_STA, 32'h0}, {OFF_AEN0, 32'h0}};
  logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h0;
  logic [31:0]        pwdata = 32'h0, rk = 32'h0, pw = PW0;
  logic [NUM_IRQ-1:0] irq_lines = '0;
  logic               kernel_run = 1'b1, fetch_req = 1'b0, fetch_blk = 1'b0, dl_page_req = 1'b0;
  logic               ecc_fix = 1'b0, ecc_fail = 1'b0;
  logic [23:0]        sign_crc = 24'h5a5a5a;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, slverr, swd_enable, fetch_stall, cmd_irq, dl_reject;
  logic [1:0]         cache_inval;
  logic [1:0]         inval_seen = 2'h0;
  int                 bad_count = 0, tests_run = 0, cyc = 0, irq_seen = 0, rej_seen = 0;

  fpa_link_if fpa_link_if_inst (.pclk(pclk), .presetn(presetn));
  fpa_link_ctrl fpa_link_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lnk(fpa_link_if_inst));
  fpa_flash_dev #(.ERASE_CYCLES(200), .SIGN_USER_CYCLES(100)) fpa_flash_dev_inst (.pclk(pclk),
    .presetn(presetn), .lnk(fpa_link_if_inst), .irq_lines(irq_lines), .kernel_run(kernel_run),
    .prot_word0(pw), .prot_word1(~pw), .rp_key0(rk), .rp_key1(rk), .ecc_fix(ecc_fix), .ecc_fail(ecc_fail),
    .sign_crc(sign_crc), .dl_mass_req(1'b0), .dl_page_req(dl_page_req), .dl_addr(32'h0),
    .fetch_req(fetch_req), .fetch_blk(fetch_blk), .swd_enable(swd_enable), .fetch_stall(fetch_stall),
    .cmd_irq(cmd_irq), .dl_reject(dl_reject), .cache_inval(cache_inval));
  fpa_assertions fpa_assertions_inst (.pclk(pclk), .presetn(presetn), .req(fpa_link_if_inst.req),
    .we(fpa_link_if_inst.we), .addr(fpa_link_if_inst.addr), .wdata(fpa_link_if_inst.wdata),
    .ack(fpa_link_if_inst.ack), .rdata(fpa_link_if_inst.rdata));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // entered just after an edge; leaves one idle cycle so psel never toggles twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // no limit of its own: the cycle guard ends a hang as a mismatch
  task automatic dev(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, HOFF_ADDR, {23'h0, w, a});
    apb(1'b1, HOFF_WDATA, d);
    apb(1'b1, HOFF_GO, 32'h1);
    do begin
      apb(1'b0, HOFF_STAT, 32'h0);
    end while (rd[1:0] !== 2'b10);
    if (!w) apb(1'b0, HOFF_RDATA, 32'h0);
  endtask : dev

  task automatic idle();
    do begin
      dev(1'b0, OFF_STA, 32'h0);
    end while (rd[STA_BUSY] !== 1'b0);
  endtask : idle

  initial forever #10 pclk = ~pclk;

  // hang guard: the whole sequence needs well under a quarter of this
  always @(posedge pclk) begin
    cyc++;
    irq_seen += (cmd_irq === 1'b1);
    rej_seen += (dl_reject === 1'b1);
    inval_seen <= inval_seen | cache_inval;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b1, 8'h40, 32'h0);
    chk("pslverr", 32'h1, {31'h0, slverr});
    for (int i = 0; i < 6; i++) begin
      dev(1'b0, ROWS[i][39:32], 32'h0);
      chk("reset value", ROWS[i][31:0], rd);
    end
    chk("swd", 32'h0, {31'h0, swd_enable});
    kernel_run <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("swd", 32'h1, {31'h0, swd_enable});
    dev(1'b1, OFF_KEY, USER_KEY);
    dev(1'b1, OFF_CON1, 32'h0);
    chk("swd", 32'h0, {31'h0, swd_enable});
    dev(1'b1, OFF_CON1, 32'h1);
    dev(1'b1, OFF_KEY, 32'h0);
    dev(1'b1, OFF_CON1, 32'h0);
    chk("swd", 32'h1, {31'h0, swd_enable});
    dev(1'b1, OFF_KEY, USER_KEY ^ 32'h1);
    dev(1'b1, OFF_CMD, CMD_SIGN);
    idle();
    chk("result", RES_DENIED, rd[5:4]);
    dev(1'b1, OFF_ADR0, 32'h800);
    dev(1'b1, OFF_ADR1, 32'h800);
    dev(1'b1, OFF_KEY, USER_KEY);
    dev(1'b1, OFF_CMD, CMD_SIGN);
    idle();
    chk("result", RES_OK, rd[5:4]);
    dev(1'b0, OFF_SIG, 32'h0);
    chk("signature", 32'h005a5a5a, rd);
    sign_crc <= 24'h0;
    dev(1'b1, OFF_KEY, USER_KEY);
    dev(1'b1, OFF_CMD, CMD_SIGN);
    ecc_fix <= 1'b1;
    @(posedge pclk);
    ecc_fix <= 1'b0;
    ecc_fail <= 1'b1;
    @(posedge pclk);
    ecc_fail <= 1'b0;
    idle();
    chk("sign ecc flags", 32'h3, rd[8:7]);
    dev(1'b0, OFF_SIG, 32'h0);
    chk("signature kept", 32'h005a5a5a, rd);
    dev(1'b1, OFF_CMD, CMD_SIGN);
    idle();
    chk("result", RES_DENIED, rd[5:4]);
    dev(1'b1, OFF_CON0, 32'h1);
    dev(1'b1, OFF_ADR0, 32'h4000);
    dev(1'b1, OFF_KEY, USER_KEY);
    dev(1'b1, OFF_CMD, CMD_PERASE);
    idle();
    chk("result", RES_PROT, rd[5:4]);
    chk("cmd_irq", 32'h1, irq_seen);
    dev(1'b1, OFF_AEN0, 32'h8);
    dev(1'b1, OFF_ADR0, 32'h5000);
    dev(1'b1, OFF_KEY, USER_KEY);
    dev(1'b1, OFF_CMD, CMD_PERASE);
    fetch_req <= 1'b1;
    @(posedge pclk);
    chk("stall", 32'h1, {31'h0, fetch_stall});
    fetch_blk <= 1'b1;
    @(posedge pclk);
    chk("stall", 32'h0, {31'h0, fetch_stall});
    irq_lines[3] <= 1'b1;
    idle();
    chk("fail and result", 32'h7, rd[6:4]);
    dev(1'b1, OFF_KEY, USER_KEY);
    dev(1'b1, OFF_CMD, CMD_SIGN);
    idle();
    chk("fail and result", 32'h7, rd[6:4]);
    irq_lines <= '0;
    dev(1'b1, OFF_KEY, USER_KEY);
    dev(1'b1, OFF_CMD, CMD_PERASE);
    dev(1'b1, OFF_CMD, CMD_ABORT);
    idle();
    chk("fail and result", 32'h7, rd[6:4]);
    dev(1'b1, OFF_CKEY, USER_KEY);
    dev(1'b1, OFF_CSETUP, 32'h10003);
    chk("inval", 32'h3, {30'h0, inval_seen});
    repeat (20) @(posedge pclk);
    dev(1'b0, OFF_CSTAT, 32'h0);
    chk("cstat", 32'h0, rd & 32'h10001);
    // second reset with the read lock stored, no write protection on block 0 and block 1 fully protected
    rk <= RP_VALUE; // lock value on both key words; rk drives rp_key0 and rp_key1
    pw <= 32'h0;
    kernel_run <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    kernel_run <= 1'b0;
    dev(1'b0, OFF_PRO0, 32'h0);
    chk("pro0", 32'h0, rd);
    chk("swd", 32'h0, {31'h0, swd_enable});
    dl_page_req <= 1'b1;
    @(posedge pclk);
    dl_page_req <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("reject", 32'h1, rej_seen);
    dev(1'b1, OFF_KEY, USER_KEY);
    dev(1'b1, OFF_PRO0, 32'h1);
    dev(1'b1, OFF_CON1, 32'h5);
    dev(1'b1, OFF_KEY, 32'h0);
    dev(1'b0, OFF_PRO0, 32'h0);
    chk("pro0", 32'h1, rd);
    dev(1'b1, OFF_AEN0, 32'h8);
    irq_lines[3] <= 1'b1;
    dev(1'b1, OFF_FLADR, 32'h1000);
    dev(1'b1, OFF_DATA1, 32'h0);
    dev(1'b1, OFF_DATA1, 32'h0);
    idle();
    chk("fail and result", 32'h7, rd[6:4]);
    complete_run();
  end
endmodule : flash_protect_abort_ctrl_bench
